// *** rtl/pric_pkg.sv ***
// Purpose: Constants and types of the init controller
// Assumes: One clock domain, 32-bit Avalon-MM access
// Notes:   Each offset, field and count is named with a PRIC_ prefix
package pric_pkg;

   // -------------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [3:0] PRIC_OFS_CTRL  = 4'h0;
   localparam logic [3:0] PRIC_OFS_STAT  = 4'h4;
   localparam logic [3:0] PRIC_OFS_IRQ   = 4'h8;
   localparam logic [3:0] PRIC_OFS_MASK  = 4'hC;

   // -------------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------------
   localparam int         PRIC_CTRL_CHK  = 0;  // Reset length check
   localparam logic       PRIC_CTRL_RST  = 1'b1;
   localparam int         PRIC_ST_FAIL   = 0;
   localparam int         PRIC_ST_ACK    = 1;
   localparam int         PRIC_ST_FLOAT  = 2;
   localparam int         PRIC_ST_SELFTEST_SELECT  = 3;
   localparam int         PRIC_ST_DIV1   = 4;
   localparam int         PRIC_ST_INRST  = 5;
   localparam int         PRIC_ST_FSM    = 8;  // Three bits wide
   localparam int         PRIC_EV_W      = 4;
   localparam int         PRIC_EV_SHORT  = 0;  // Reset held too short
   localparam int         PRIC_EV_FAIL   = 1;  // Init test failed
   localparam int         PRIC_EV_DONE   = 2;  // Init completed
   localparam int         PRIC_EV_FLOAT  = 3;  // Float mode entered
   localparam logic [3:0] PRIC_MASK_RST  = 4'h0;

   // -------------------------------------------------------------------
   // Timing counts, in core ticks
   // -------------------------------------------------------------------
   localparam int         PRIC_RCNT_W    = 14;
   localparam int         PRIC_MIN_DIV2  = 16;
   localparam int         PRIC_MIN_DIV1  = 10000;

   // -------------------------------------------------------------------
   // Init sequencer states and module state
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      PRIC_S_RESET,
      PRIC_S_INT_TEST,
      PRIC_S_INT_PASS,
      PRIC_S_BUS_TEST,
      PRIC_S_RUN,
      PRIC_S_FAIL,
      PRIC_S_FLOAT
   } pric_fsm_t;

   typedef struct packed {
      logic                   rst_m;     // Reset pin, first stage
      logic                   rst_s;     // Reset pin, synced (low=reset)
      logic                   rst_d;     // Synced reset pin, delayed
      logic                   hold_m;
      logic                   hold_s;
      logic                   stst_m;
      logic                   stst_s;
      logic                   flt_m;
      logic                   flt_s;     // Synced float pin (low=float)
      logic                   cdiv_m;
      logic                   cdiv_s;
      pric_fsm_t              fsm;
      logic                   selftest_select;     // Latched self-test select
      logic                   flt_req;   // Float sampled during reset
      logic [PRIC_RCNT_W-1:0] rcnt;
      logic                   fail;
      logic                   ack;
      logic                   ustart;
      logic                   rsp;
      logic [31:0]            rdata;
      logic                   chk;
      logic [PRIC_EV_W-1:0]   ist;
      logic [PRIC_EV_W-1:0]   imask;
   } pric_state_t;

   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } pric_avm_req_t;

endpackage

// *** rtl/pric_clk_div.sv ***
// Purpose: Internal tick and output clock from the input clock
// Assumes: sys_clk_i is the input clock; div_by_one_i synchronised
// Notes:   The tick is one cycle wide; the output clock toggles
//          on each tick, a square wave at half the tick rate
`timescale 1ns/100ps
module pric_clk_div
   import pric_pkg::*;
(
   // Clock, reset, enable
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic clk_en_i,
   // Division control
   input  wire logic div_by_one_i,
   // Divided outputs
   output logic      tick_o,
   output logic      pclk_o
);

   typedef struct packed {
      logic phase;
      logic tick;
      logic pclk;
   } pric_div_t;

   pric_div_t q;
   pric_div_t next_q;

   // Tick every cycle in 1x, every other cycle in 2x
   always_comb begin
      next_q       = q;
      next_q.phase = ~q.phase;
      next_q.tick  = div_by_one_i | q.phase;
      if (q.tick) begin
         next_q.pclk = ~q.pclk;
      end
   end

   // State register, frozen while clk_en_i is low
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else if (clk_en_i) begin
         q <= next_q;
      end
   end

   assign tick_o = q.tick;
   assign pclk_o = q.pclk;

endmodule

// *** rtl/pric_top.sv ***
// Purpose: Reset, self-test, hold and float control of a core
// Assumes: Pins are asynchronous and pass two flip-flops first;
//          test results come on the same clock
// Notes:   Avalon-MM access always takes one wait state
`timescale 1ns/100ps
module pric_top
   import pric_pkg::*;
#(
   parameter int MIN_DIV1_CYC = PRIC_MIN_DIV1,
   parameter int MIN_DIV2_CYC = PRIC_MIN_DIV2
)(
   // Clock, reset, enable
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        clk_en_i,
   // Board pins, asynchronous
   input  wire logic        reset_pin_n_i,
   input  wire logic        hold_req_i,
   input  wire logic        selftest_select_i,
   input  wire logic        emulation_float_mode_n_i,
   input  wire logic        clock_divide_select_i,
   // Core test engines, same clock
   input  wire logic        int_test_done_i,
   input  wire logic        int_test_pass_i,
   input  wire logic        bus_test_done_i,
   input  wire logic        bus_test_pass_i,
   // Pin and core outputs
   output logic             fail_o,
   output logic             bus_grant_ack_o,
   output logic             bus_float_o,
   output logic             pins_oe_o,
   output logic             core_in_reset_o,
   output logic             int_test_run_o,
   output logic             bus_test_run_o,
   output logic             user_start_o,
   output logic             core_tick_o,
   output logic             processor_output_clock_o,
   // Avalon-MM slave
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Interrupt
   output logic             irq_o
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   localparam logic [PRIC_RCNT_W-1:0] MIN_DIV1 =
      PRIC_RCNT_W'(MIN_DIV1_CYC);
   localparam logic [PRIC_RCNT_W-1:0] MIN_DIV2 =
      PRIC_RCNT_W'(MIN_DIV2_CYC);
   localparam logic [PRIC_RCNT_W-1:0] RCNT_MAX = '1;

   pric_state_t          q;
   pric_state_t          next_q;
   pric_avm_req_t        req;
   logic                 tick;
   logic                 pclk;
   logic                 pin_rst;
   logic                 rise;
   logic                 in_float;
   logic                 acc;
   logic [PRIC_EV_W-1:0] ev;
   logic [31:0]          stat_word;
   logic [31:0]          rd_mux;
   logic [PRIC_RCNT_W-1:0] min_len;

   assign req.read       = avs_read_i;
   assign req.write      = avs_write_i;
   assign req.address    = avs_address_i;
   assign req.byteenable = avs_byteenable_i;
   assign req.writedata  = avs_writedata_i;

   // -------------------------------------------------------------------
   // Clock divider
   // -------------------------------------------------------------------
   pric_clk_div u_div (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .clk_en_i     (clk_en_i),
      .div_by_one_i (q.cdiv_s),
      .tick_o       (tick),
      .pclk_o       (pclk)
   );

   // -------------------------------------------------------------------
   // Decode of synchronised pins
   // -------------------------------------------------------------------
   // Only the second sync stage is looked at; the first can be metastable
   assign pin_rst  = ~q.rst_s;
   assign rise     = q.rst_s & ~q.rst_d;     // Reset pin released
   assign in_float = (q.fsm == PRIC_S_FLOAT);
   assign acc      = (req.read | req.write) & q.rsp;
   assign min_len  = q.cdiv_s ? MIN_DIV1 : MIN_DIV2;

   // Status word seen by software
   always_comb begin
      stat_word                     = '0;
      stat_word[PRIC_ST_FAIL]       = q.fail;
      stat_word[PRIC_ST_ACK]        = q.ack;
      stat_word[PRIC_ST_FLOAT]      = in_float;
      stat_word[PRIC_ST_SELFTEST_SELECT]      = q.selftest_select;
      stat_word[PRIC_ST_DIV1]       = q.cdiv_s;
      stat_word[PRIC_ST_INRST]      = pin_rst;
      stat_word[PRIC_ST_FSM +: 3]   = q.fsm;
   end

   // Read multiplexer; unmapped offsets read as zero
   always_comb begin
      rd_mux = '0;
      case (req.address)
         PRIC_OFS_CTRL: begin
            rd_mux[PRIC_CTRL_CHK] = q.chk;
         end
         PRIC_OFS_STAT: begin
            rd_mux = stat_word;
         end
         PRIC_OFS_IRQ: begin
            rd_mux[PRIC_EV_W-1:0] = q.ist;
         end
         PRIC_OFS_MASK: begin
            rd_mux[PRIC_EV_W-1:0] = q.imask;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      next_q = q;
      ev     = '0;

      // Two-flop synchronisers on board pins
      next_q.rst_m  = reset_pin_n_i;
      next_q.rst_s  = q.rst_m;
      next_q.rst_d  = q.rst_s;
      next_q.hold_m = hold_req_i;
      next_q.hold_s = q.hold_m;
      next_q.stst_m = selftest_select_i;
      next_q.stst_s = q.stst_m;
      next_q.flt_m  = emulation_float_mode_n_i;
      next_q.flt_s  = q.flt_m;
      next_q.cdiv_m = clock_divide_select_i;
      next_q.cdiv_s = q.cdiv_m;

      // Grant follows the request in reset and out, so a
      // grant standing at reset is kept until hold drops
      next_q.ack = q.hold_s;

      next_q.ustart = 1'b0;

      // Reset length, counted in ticks
      if (pin_rst) begin
         if (tick && q.rcnt != RCNT_MAX) begin
            next_q.rcnt = q.rcnt + 1'b1;
         end
      end else begin
         next_q.rcnt = '0;
      end
      if (rise && q.chk && q.rcnt < min_len) begin
         ev[PRIC_EV_SHORT] = 1'b1;
      end

      // Init sequencer
      if (pin_rst) begin
         // Core held in reset; pins show reset values
         next_q.fsm     = PRIC_S_RESET;
         next_q.fail    = 1'b0;
         next_q.selftest_select   = q.stst_s;
         next_q.flt_req = ~q.flt_s;
      end else begin
         case (q.fsm)
            PRIC_S_RESET: begin
               if (rise) begin
                  // The self-test select is taken as the pin releases
                  next_q.selftest_select = q.stst_s;
                  if (q.flt_req) begin
                     next_q.fsm   = PRIC_S_FLOAT;
                     ev[PRIC_EV_FLOAT] = 1'b1;
                  end else begin
                     next_q.fail = 1'b1;
                     next_q.fsm  = q.stst_s ?
                                   PRIC_S_INT_TEST :
                                   PRIC_S_BUS_TEST;
                  end
               end
            end
            PRIC_S_INT_TEST: begin
               if (tick && int_test_done_i) begin
                  if (int_test_pass_i) begin
                     next_q.fail = 1'b0;
                     next_q.fsm  = PRIC_S_INT_PASS;
                  end else begin
                     next_q.fsm  = PRIC_S_FAIL;
                     ev[PRIC_EV_FAIL] = 1'b1;
                  end
               end
            end
            PRIC_S_INT_PASS: begin
               // Failure released one tick, then rearmed
               if (tick) begin
                  next_q.fail = 1'b1;
                  next_q.fsm  = PRIC_S_BUS_TEST;
               end
            end
            PRIC_S_BUS_TEST: begin
               if (tick && bus_test_done_i) begin
                  if (bus_test_pass_i) begin
                     next_q.fail   = 1'b0;
                     next_q.ustart = 1'b1;
                     next_q.fsm    = PRIC_S_RUN;
                     ev[PRIC_EV_DONE] = 1'b1;
                  end else begin
                     next_q.fsm    = PRIC_S_FAIL;
                     ev[PRIC_EV_FAIL] = 1'b1;
                  end
               end
            end
            PRIC_S_RUN: begin
               next_q.fail = 1'b0;
            end
            PRIC_S_FAIL: begin
               next_q.fail = 1'b1;
            end
            PRIC_S_FLOAT: begin
               // Left only through the reset branch above
               next_q.fsm = PRIC_S_FLOAT;
            end
            default: begin
               next_q.fsm = PRIC_S_RESET;
            end
         endcase
      end

      // One wait state on every access
      next_q.rsp = (req.read | req.write) & ~q.rsp;
      if ((req.read | req.write) && !q.rsp) begin
         next_q.rdata = req.read ? rd_mux : '0;
      end

      // Writes use byte lane 0 only; all fields live there
      if (acc && req.write && req.byteenable[0]) begin
         case (req.address)
            PRIC_OFS_CTRL: begin
               next_q.chk = req.writedata[PRIC_CTRL_CHK];
            end
            PRIC_OFS_MASK: begin
               next_q.imask = req.writedata[PRIC_EV_W-1:0];
            end
            default: begin
               next_q.chk = q.chk;
            end
         endcase
      end

      // Sticky events: a read clears only what it reported, so an event
      // landing in the clearing cycle survives
      if (acc && req.read && req.address == PRIC_OFS_IRQ) begin
         next_q.ist = (q.ist & ~q.rdata[PRIC_EV_W-1:0]) | ev;
      end else begin
         next_q.ist = q.ist | ev;
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q         <= '0;
         q.rst_m   <= 1'b0;
         q.rst_s   <= 1'b0;
         q.rst_d   <= 1'b0;
         q.flt_m   <= 1'b1;
         q.flt_s   <= 1'b1;
         q.fsm     <= PRIC_S_RESET;
         q.chk     <= PRIC_CTRL_RST;
         q.imask   <= PRIC_MASK_RST;
      end else if (clk_en_i) begin
         q <= next_q;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Float releases every pin; the grant floats only the bus
   assign pins_oe_o                = ~in_float;
   assign fail_o                   = q.fail;
   assign bus_grant_ack_o          = q.ack;
   assign bus_float_o              = q.ack | in_float;
   assign core_in_reset_o          = (q.fsm == PRIC_S_RESET);
   assign int_test_run_o           = (q.fsm == PRIC_S_INT_TEST);
   assign bus_test_run_o           = (q.fsm == PRIC_S_BUS_TEST);
   assign user_start_o             = q.ustart;
   assign core_tick_o              = tick;
   assign processor_output_clock_o = pclk;
   assign avs_readdata_o           = q.rdata;
   assign avs_waitrequest_o        = (req.read | req.write) & ~q.rsp;
   assign irq_o                    = |(q.ist & q.imask);

endmodule

// *** bench/pric_monitor.sv ***
// Purpose: Port checks of the init controller
// Assumes: clk_en_i high; pins change slowly
// Notes:   Bound to every pric_top instance
`timescale 1ns/100ps
module pric_monitor (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // Watched inputs
   input  wire logic hold_req_i,
   input  wire logic clock_divide_select_i,
   input  wire logic avs_read_i,
   input  wire logic avs_write_i,
   // Watched outputs
   input  wire logic fail_o,
   input  wire logic bus_grant_ack_o,
   input  wire logic bus_float_o,
   input  wire logic pins_oe_o,
   input  wire logic core_in_reset_o,
   input  wire logic int_test_run_o,
   input  wire logic bus_test_run_o,
   input  wire logic user_start_o,
   input  wire logic core_tick_o,
   input  wire logic avs_waitrequest_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // ------------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------------
   // Six samples cover the pin synchroniser and a register
   sequence s_hold_on;
      hold_req_i [*6];
   endsequence
   sequence s_new_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_passed;
      user_start_o && !fail_o;
   endsequence

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_ack_when_held: assert property (s_hold_on |-> bus_grant_ack_o)
      else $error("hold not acked");
   a_ack_drops: assert property (!hold_req_i [*6] |-> !bus_grant_ack_o)
      else $error("ack kept after hold");
   a_ack_floats: assert property (bus_grant_ack_o |-> bus_float_o)
      else $error("bus not floated");
   a_req_waits: assert property (s_new_req |=> !avs_waitrequest_o)
      else $error("extra wait state");
   a_reset_quiet: assert property (core_in_reset_o |-> !fail_o &&
      !user_start_o && !int_test_run_o && !bus_test_run_o)
      else $error("active in reset");
   a_init_starts: assert property ($fell(core_in_reset_o) |->
      ##[0:2] (fail_o || !pins_oe_o)) else $error("fail not raised");
   a_fail_rise: assert property ($rose(fail_o) |->
      int_test_run_o || bus_test_run_o) else $error("fail rose outside test");
   a_fail_fall: assert property ($fell(fail_o) |->
      !int_test_run_o && !bus_test_run_o) else $error("fail fell in test");
   a_start_clean: assert property (user_start_o |-> s_passed
      ##1 !user_start_o) else $error("bad start pulse");
   a_pass_holds: assert property (user_start_o |=> !fail_o [*8])
      else $error("fail after init pass");
   a_float_quiet: assert property (!pins_oe_o |-> bus_float_o &&
      !fail_o && !user_start_o) else $error("active in float");
   a_div_one: assert property (clock_divide_select_i [*6] |->
      core_tick_o) else $error("1x tick missing");
   a_div_two: assert property (!clock_divide_select_i [*6] |=>
      core_tick_o != $past(core_tick_o)) else $error("2x tick stuck");
endmodule

bind pric_top pric_monitor i_pric_monitor (.*);

// *** bench/pric_board_model.sv ***
// Purpose: Board reset, pin strap and core test engine model
// Assumes: Driven through its tasks and fields
// Notes:   Released pass lines alternate instead of holding; done lines drop low
`timescale 1ns/100ps
module pric_board_model (
   // Clock and design status
   input  wire logic sys_clk_i,
   input  wire logic core_tick_i,
   input  wire logic int_run_i,
   input  wire logic bus_run_i,
   // Board pins
   output logic      reset_pin_n_o,
   output logic      hold_req_o,
   output logic      selftest_o,
   output logic      float_n_o,
   output logic      div_sel_o,
   // Test engine results
   output logic      int_done_o,
   output logic      int_pass_o,
   output logic      bus_done_o,
   output logic      bus_pass_o
);
   logic int_ok = 1'b1;
   logic bus_ok = 1'b1;
   int   lat    = 3;   // Ticks per test
   int   ic     = 0;
   int   bc     = 0;

   // Reset held from power-up while the clock already runs
   initial begin
      reset_pin_n_o = 1'b0;
      hold_req_o = 1'b0;
      selftest_o = 1'b1;
      float_n_o = 1'b1;
      div_sel_o = 1'b0;
      int_done_o = 1'b0;
      int_pass_o = 1'b0;
      bus_done_o = 1'b0;
      bus_pass_o = 1'b0;
   end

   // Engines answer after lat ticks of their run line
   always @(posedge sys_clk_i) begin
      ic <= (int_run_i === 1'b1) ? ic + 32'(core_tick_i === 1'b1) : 0;
      bc <= (bus_run_i === 1'b1) ? bc + 32'(core_tick_i === 1'b1) : 0;
      int_done_o <= (int_run_i === 1'b1) && ic >= lat;
      bus_done_o <= (bus_run_i === 1'b1) && bc >= lat;
      int_pass_o <= (int_run_i === 1'b1 && ic >= lat) ? int_ok : !int_pass_o;
      bus_pass_o <= (bus_run_i === 1'b1 && bc >= lat) ? bus_ok : !bus_pass_o;
   end

   // Reset and straps, in either order
   task automatic press(input logic st, input logic fl);
      @(posedge sys_clk_i);
      reset_pin_n_o <= 1'b0;
      selftest_o <= st;
      float_n_o <= !fl;
   endtask

   // Release, keep the clock 32 periods
   task automatic lift();
      @(posedge sys_clk_i);
      reset_pin_n_o <= 1'b1;
      repeat (32) @(posedge sys_clk_i);
   endtask
endmodule

// *** bench/pric_tb_top.sv ***
// Purpose: Self-checking bench of the init controller
// Assumes: clk_en_i tied high; board model drives the pins
// Notes:   1x minimum reset shortened to 40 ticks
`timescale 1ns/100ps
module pric_tb_top;
   import pric_pkg::*;
   logic        sys_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [3:0]  avs_address_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic [31:0] rd;
   logic        reset_pin_n_i, hold_req_i, selftest_select_i;
   logic        emulation_float_mode_n_i, clock_divide_select_i;
   logic        int_test_done_i, int_test_pass_i;
   logic        bus_test_done_i, bus_test_pass_i;
   logic        fail_o, bus_grant_ack_o, bus_float_o, pins_oe_o;
   logic        core_in_reset_o, int_test_run_o, bus_test_run_o;
   logic        user_start_o, core_tick_o, processor_output_clock_o;
   logic        avs_waitrequest_o, irq_o;
   logic        saw_fail = 1'b0;
   logic        saw_int = 1'b0;
   logic        saw_bus = 1'b0;
   logic        saw_start = 1'b0;
   int          num_errors = 0;
   int          checked = 0;

   // ------------------------------------------------------------------
   // Clock, design and board
   // ------------------------------------------------------------------
   always #5 sys_clk_i = !sys_clk_i;

   pric_top #(.MIN_DIV1_CYC(40), .MIN_DIV2_CYC(PRIC_MIN_DIV2)) i_dut (.*,
      .clk_en_i(1'b1), .avs_byteenable_i(4'hF));

   pric_board_model i_board (.sys_clk_i(sys_clk_i),
      .core_tick_i(core_tick_o), .int_run_i(int_test_run_o),
      .bus_run_i(bus_test_run_o), .reset_pin_n_o(reset_pin_n_i),
      .hold_req_o(hold_req_i), .selftest_o(selftest_select_i),
      .float_n_o(emulation_float_mode_n_i),
      .div_sel_o(clock_divide_select_i), .int_done_o(int_test_done_i),
      .int_pass_o(int_test_pass_i), .bus_done_o(bus_test_done_i),
      .bus_pass_o(bus_test_pass_i));

   // What the init sequence showed since the last boot
   always @(posedge sys_clk_i) begin
      if (user_start_o === 1'b1) saw_start <= 1'b1;
      if (fail_o === 1'b1) saw_fail <= 1'b1;
      if (int_test_run_o === 1'b1) saw_int <= 1'b1;
      if (bus_test_run_o === 1'b1) saw_bus <= 1'b1;
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One Avalon transfer, held until waitrequest samples low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_address_i <= a;
      avs_writedata_i <= wd;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         n++;
         if (n > 20) begin
            num_errors++;
            report_and_stop();
         end
         @(posedge sys_clk_i);
      end
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                      input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   // Bounded wait for irq or a user start; the pulse may come early
   task automatic wait_for(input logic on_irq);
      int n;
      n = 0;
      while ((on_irq ? irq_o : saw_start) !== 1'b1) begin
         @(posedge sys_clk_i);
         n++;
         if (n > 3000) begin
            num_errors++;
            report_and_stop();
         end
      end
      saw_start <= 1'b0;
   endtask

   // Board reset of at least n ticks in either mode
   task automatic boot(input logic st, input logic fl, input int n);
      i_board.press(st, fl);
      repeat (2 * n + 2) @(posedge sys_clk_i);
      saw_fail <= 1'b0;
      saw_int <= 1'b0;
      saw_bus <= 1'b0;
      i_board.lift();
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rdc(4'h0, 32'h1, "ctrl");
      rdc(4'hC, 32'h0, "mask");
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      rdc(4'h2, 32'h0, "unmapped");
      bus(1'b1, 4'hC, 32'hF);
      // Both tests pass in 2x mode
      boot(1'b1, 1'b0, PRIC_MIN_DIV2);
      wait_for(1'b0);
      chk("fail seen", 32'h1, 32'(saw_fail));
      chk("int ran", 32'h1, 32'(saw_int));
      rdc(4'h4, 32'h408, "status run");
      chk("irq", 32'h1, 32'(irq_o));
      rdc(4'h8, 32'h4, "irq done");
      rdc(4'h8, 32'h0, "irq cleared");
      // Select dropped late in reset: bus test only
      bus(1'b1, 4'hC, 32'h0);
      i_board.press(1'b1, 1'b0);
      repeat (40) @(posedge sys_clk_i);
      i_board.selftest_o <= 1'b0;
      saw_int <= 1'b0;
      saw_bus <= 1'b0;
      i_board.lift();
      wait_for(1'b0);
      chk("int ran", 32'h0, 32'(saw_int));
      chk("bus ran", 32'h1, 32'(saw_bus));
      chk("irq masked", 32'h0, 32'(irq_o));
      rdc(4'h8, 32'h4, "irq done");
      bus(1'b1, 4'hC, 32'hF);
      // Internal test fails, then the bus test fails
      i_board.int_ok = 1'b0;
      boot(1'b1, 1'b0, PRIC_MIN_DIV2);
      wait_for(1'b1);
      chk("fail int", 32'h1, 32'(fail_o));
      chk("bus ran", 32'h0, 32'(saw_bus));
      rdc(4'h8, 32'h2, "irq fail");
      i_board.int_ok = 1'b1;
      i_board.bus_ok = 1'b0;
      boot(1'b1, 1'b0, PRIC_MIN_DIV2);
      wait_for(1'b1);
      chk("fail bus", 32'h1, 32'(fail_o));
      rdc(4'h8, 32'h2, "irq fail");
      i_board.bus_ok = 1'b1;
      // Short 1x reset, hold arriving in reset
      i_board.press(1'b1, 1'b0);
      i_board.div_sel_o <= 1'b1;
      i_board.hold_req_o <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
      chk("ack in reset", 32'h1, 32'(bus_grant_ack_o));
      i_board.hold_req_o <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      i_board.lift();
      wait_for(1'b0);
      rdc(4'h8, 32'h5, "irq short");
      boot(1'b1, 1'b0, 40);
      wait_for(1'b0);
      rdc(4'h8, 32'h4, "irq long");
      i_board.div_sel_o <= 1'b0;
      // Float entry, hold, then exit with float pin high
      boot(1'b1, 1'b1, PRIC_MIN_DIV2);
      chk("oe", 32'h0, 32'(pins_oe_o));
      chk("float", 32'h1, 32'(bus_float_o));
      rdc(4'h8, 32'h8, "irq float");
      chk("oe held", 32'h0, 32'(pins_oe_o));
      boot(1'b1, 1'b0, PRIC_MIN_DIV2);
      chk("oe back", 32'h1, 32'(pins_oe_o));
      wait_for(1'b0);
      rdc(4'h8, 32'h4, "irq done");
      // Grant held at reset stays until hold drops
      i_board.hold_req_o <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      i_board.press(1'b1, 1'b0);
      repeat (10) @(posedge sys_clk_i);
      chk("ack kept", 32'h1, 32'(bus_grant_ack_o));
      chk("fail reset", 32'h0, 32'(fail_o));
      i_board.hold_req_o <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      chk("ack dropped", 32'h0, 32'(bus_grant_ack_o));
      i_board.lift();
      wait_for(1'b0);
      report_and_stop();
   end
endmodule
